// [design/fpco_top.sv]
// Module: field pair changeover control with configuration store and bus slave
// ============================================================================
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module fpco_top import fpco_pkg::*; #(
  parameter logic [31:0] ENG_KEY = 32'h0000_5afe  // Arbitrary access key
) (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic [SELW-1:0] select_inputs,
  input  wire logic            enable_ok,
  input  wire logic            unit_swap,
  output logic      [3:0]      active_pair,
  output logic      [3:0]      incoming_pair,
  output logic                 overlap_active,
  output logic                 func_b_active,
  output logic                 safety_on,
  output logic                 cfg_fault
);

  fpco_reg_if rb ();

  fpco_core_t         q;
  fpco_core_t         d;
  logic [SELW+1:0]    sy;
  logic [SELW-1:0]    sel;
  logic               ok;
  logic               swap;
  logic [4:0]         req;
  logic               cfg_wr;
  logic               rst_eng;
  logic               stable;
  logic [3:0]         wix;

  // ==========================================================================
  // Bus front end and pin synchronisers
  fpco_ahb u_ahb (
    .clk       (clk),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .rb        (rb)
  );

  fpco_sync #(.W(SELW + 2)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    ({unit_swap, enable_ok, select_inputs}),
    .dout   (sy)
  );

  assign sel  = sy[SELW-1:0];
  assign ok   = sy[SELW];
  assign swap = sy[SELW+1];

  // ==========================================================================
  // Helpers
  // Returns {valid, index}; valid only for exactly one active enabled input (overlap mode: in the first enabled group)
  function automatic logic [4:0] fpco_decode(input logic [SELW-1:0] s,
                                             input logic [1:0] g,
                                             input logic ov);
    logic [SELW-1:0] m;
    logic [3:0]      ix;
    logic [3:0]      n1;
    m = s & {{5{g[1]}}, {5{g[0]}}};
    if (ov) begin
      // Five pairs: first enabled group only
      m = g[0] ? {5'h00, s[4:0]} : (g[1] ? {5'h00, s[9:5]} : 10'h000);
    end
    ix = 4'h0;
    n1 = 4'h0;
    for (int i = 0; i < SELW; i++) begin
      if (m[i]) begin
        ix = 4'(i);
        n1 = n1 + 4'h1;
      end
    end
    return {n1 == 4'h1, ix};
  endfunction

  function automatic logic fpco_valid(input fpco_cfg_t c);
    return (c.mode != MODE_BAD) &&
           ((c.mode == MODE_FIXED) || ((c.chg_time != 16'h0000) && (c.grp != 2'h0)));
  endfunction

  function automatic logic fpco_allowed(input fpco_cfg_t c, input logic [3:0] a,
                                        input logic [3:0] b);
    return !c.mon || c.seq[a][b];
  endfunction

  // ==========================================================================
  // Register read mux (reads show the configuration in force)
  always_comb begin
    unique case (rb.addr)
      ADR_CTRL:   rb.rdata = {25'h0, q.cu.auto_rst, q.cu.two_fn, q.cu.mon, q.cu.grp,
                              q.cu.mode};
      ADR_TIME:   rb.rdata = {16'h0000, q.cu.chg_time};
      ADR_SEQ:    rb.rdata = {12'h000, q.seq_ix, 6'h00, q.cu.seq[q.seq_ix]};
      ADR_ACCESS: rb.rdata = {31'h0, q.eng};
      ADR_STATUS: rb.rdata = {14'h0, q.st, q.su_ok, q.cu_ok, q.eng, q.xfer, q.rej,
                              q.viol, q.fault, q.safe, q.ovl, q.pb, q.pa};
      default:    rb.rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    d       = q;
    rst_eng = 1'b0;
    req     = fpco_decode(sel, q.cu.grp, q.cu.mode == MODE_OVL);
    stable  = (sel == q.sel_p);
    d.sel_p = sel;
    wix     = rb.wdata[SEQ_IX_LSB +: 4];
    cfg_wr  = rb.wr && ((rb.addr == ADR_CTRL) || (rb.addr == ADR_TIME) ||
                        (rb.addr == ADR_SEQ) || (rb.addr == ADR_CMD));

    // Sticky flags: clear first so a same-cycle set still lands
    if (rb.wr && (rb.addr == ADR_STATUS)) begin
      if (rb.wdata[ST_VIOL_BIT]) begin
        d.viol = 1'b0;
      end
      if (rb.wdata[ST_REJ_BIT]) begin
        d.rej = 1'b0;
      end
    end

    if (rb.wr && (rb.addr == ADR_ACCESS)) begin
      d.eng = (rb.wdata == ENG_KEY);
    end

    if (cfg_wr && !q.eng) begin
      d.rej = 1'b1;
    end else if (cfg_wr && (rb.addr == ADR_CMD)) begin
      if (rb.wdata[CMD_RESET_BIT]) begin
        d.cu    = CFG_DEFAULT;
        d.su    = CFG_DEFAULT;
        d.cu_ok = 1'b1;
        d.su_ok = 1'b1;
        d.fault = 1'b0;
        d.xfer  = 1'b0;
        rst_eng = 1'b1;
      end else if (rb.wdata[CMD_ABORT_BIT]) begin
        if (q.xfer) begin
          d.fault = 1'b1;
          d.xfer  = 1'b0;
        end
      end else if (rb.wdata[CMD_COMMIT_BIT]) begin
        if (!q.xfer) begin
          d.rej = 1'b1;
        end else if (fpco_valid(q.stg)) begin
          d.cu    = q.stg;
          d.su    = q.stg;
          d.cu_ok = 1'b1;
          d.su_ok = 1'b1;
          d.fault = 1'b0;
          d.xfer  = 1'b0;
          rst_eng = 1'b1;
        end else begin
          d.fault = 1'b1;
          d.xfer  = 1'b0;
        end
      end else if (rb.wdata[CMD_START_BIT]) begin
        // A restarted transfer drops the unfinished one
        d.fault = q.xfer ? 1'b1 : q.fault;
        d.xfer  = 1'b1;
        d.stg   = q.cu;
      end
    end else if (cfg_wr && !q.xfer) begin
      d.rej = 1'b1;
    end else if (cfg_wr) begin
      // Edits land in staging only; the running set is untouched
      unique case (rb.addr)
        ADR_CTRL: begin
          d.stg.mode     = fpco_mode_t'(rb.wdata[1:0]);
          d.stg.grp      = rb.wdata[3:2];
          d.stg.mon      = rb.wdata[4];
          d.stg.two_fn   = rb.wdata[5];
          d.stg.auto_rst = rb.wdata[6];
        end
        ADR_TIME: begin
          d.stg.chg_time = rb.wdata[TIMEW-1:0];
        end
        default: begin
          if (wix < 4'(NPAIR)) begin
            d.seq_ix       = wix;
            d.stg.seq[wix] = rb.wdata[NPAIR-1:0];
          end else begin
            d.rej = 1'b1;
          end
        end
      endcase
    end

    // Connection unit swap: copy back from the scanner unit copy
    d.swap_p = swap;
    if (swap && !q.swap_p) begin
      rst_eng = 1'b1;
      if (q.su_ok) begin
        d.cu    = q.su;
        d.cu_ok = 1'b1;
      end else begin
        d.cu_ok = 1'b0;
      end
    end

    // ========================================================================
    // Changeover engine
    unique case (q.cu.mode)
      MODE_FIXED: begin
        d.st  = ST_IDLE;
        d.pa  = 4'h0;
        d.pb  = 4'h0;
        d.ovl = 1'b0;
      end
      MODE_FMOM: begin
        unique case (q.st)
          ST_IDLE: begin
            if (req[4] && (req[3:0] != q.pa)) begin
              d.st  = ST_RUN;
              d.cnt = q.cu.chg_time;
            end
          end
          ST_RUN: begin
            // Inputs are not looked at until the count ends
            if (q.cnt <= 16'h0001) begin
              d.st = ST_IDLE;
              if (req[4] && stable && (req[3:0] != q.pa)) begin
                if (fpco_allowed(q.cu, q.pa, req[3:0])) begin
                  d.pa = req[3:0];
                  d.pb = req[3:0];
                end else begin
                  d.viol = 1'b1;
                end
              end
            end else begin
              d.cnt = q.cnt - 16'h0001;
            end
          end
        endcase
      end
      MODE_OVL: begin
        unique case (q.st)
          ST_IDLE: begin
            if (req[4] && (req[3:0] != q.pa)) begin
              if (fpco_allowed(q.cu, q.pa, req[3:0])) begin
                d.pb  = req[3:0];
                d.ovl = 1'b1;
                d.st  = ST_RUN;
                d.cnt = q.cu.chg_time;
              end else begin
                d.viol = 1'b1;
              end
            end
          end
          ST_RUN: begin
            if (q.cnt <= 16'h0001) begin
              d.pa  = q.pb;
              d.ovl = 1'b0;
              d.st  = ST_IDLE;
            end else begin
              d.cnt = q.cnt - 16'h0001;
            end
          end
        endcase
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    if (rst_eng) begin
      d.st  = ST_IDLE;
      d.pa  = 4'h0;
      d.pb  = 4'h0;
      d.ovl = 1'b0;
      d.cnt = 16'h0000;
    end

    // Outputs on only with a configuration in force and no fault
    d.safe = d.cu_ok && !d.fault && !d.viol && ok;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs; pair index selects protective and warning field together
  assign active_pair    = q.pa;
  assign incoming_pair  = q.pb;
  assign overlap_active = q.ovl;
  assign func_b_active  = q.cu.two_fn;
  assign safety_on      = q.safe;
  assign cfg_fault      = q.fault;

endmodule

// [pkg/fpco_pkg.sv]
// Package: shared constants and types of the field pair changeover control block
package fpco_pkg;

  // ==========================================================================
  // Sizes
  localparam int NPAIR = 10;
  localparam int SELW  = 10;
  localparam int TIMEW = 16;
  localparam int ADDRW = 8;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [ADDRW-1:0] ADR_CTRL   = 8'h00;
  localparam logic [ADDRW-1:0] ADR_TIME   = 8'h04;
  localparam logic [ADDRW-1:0] ADR_SEQ    = 8'h08;
  localparam logic [ADDRW-1:0] ADR_ACCESS = 8'h0c;
  localparam logic [ADDRW-1:0] ADR_CMD    = 8'h10;
  localparam logic [ADDRW-1:0] ADR_STATUS = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int CMD_START_BIT  = 0;
  localparam int CMD_COMMIT_BIT = 1;
  localparam int CMD_ABORT_BIT  = 2;
  localparam int CMD_RESET_BIT  = 3;
  localparam int SEQ_IX_LSB     = 16;
  localparam int ST_VIOL_BIT    = 11;
  localparam int ST_REJ_BIT     = 12;

  // ==========================================================================
  // Modes, states, configuration
  typedef enum logic [1:0] {
    MODE_FIXED = 2'h0,
    MODE_FMOM  = 2'h1,
    MODE_OVL   = 2'h2,
    MODE_BAD   = 2'h3
  } fpco_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } fpco_state_t;

  typedef struct packed {
    fpco_mode_t                 mode;
    logic [1:0]                 grp;
    logic                       mon;
    logic                       two_fn;
    logic                       auto_rst;
    logic [TIMEW-1:0]           chg_time;
    logic [NPAIR-1:0][NPAIR-1:0] seq;
  } fpco_cfg_t;

  localparam fpco_cfg_t CFG_DEFAULT = '{
    mode: MODE_FIXED, grp: 2'h0, mon: 1'b0, two_fn: 1'b0, auto_rst: 1'b0,
    chg_time: 16'h0000, seq: '0};

  typedef struct packed {
    fpco_cfg_t   cu;
    fpco_cfg_t   su;
    fpco_cfg_t   stg;
    logic        cu_ok;
    logic        su_ok;
    logic        eng;
    logic        xfer;
    logic        fault;
    logic        viol;
    logic        rej;
    logic        safe;
    logic        swap_p;
    logic [3:0]  seq_ix;
    fpco_state_t st;
    logic [TIMEW-1:0] cnt;
    logic [3:0]  pa;
    logic [3:0]  pb;
    logic        ovl;
    logic [SELW-1:0] sel_p;
  } fpco_core_t;

  localparam fpco_core_t CORE_RESET = '{
    cu: CFG_DEFAULT, su: CFG_DEFAULT, stg: CFG_DEFAULT,
    cu_ok: 1'b0, su_ok: 1'b0, eng: 1'b0, xfer: 1'b0, fault: 1'b0,
    viol: 1'b0, rej: 1'b0, safe: 1'b0, swap_p: 1'b0, seq_ix: 4'h0,
    st: ST_IDLE, cnt: 16'h0000, pa: 4'h0, pb: 4'h0, ovl: 1'b0,
    sel_p: 10'h000};

endpackage

// [pkg/fpco_reg_if.sv]
// Interface: register access strobes between bus front end and core
`timescale 1ns/100ps
interface fpco_reg_if;
  import fpco_pkg::*;
  logic             wr;
  logic             rd;
  logic [ADDRW-1:0] addr;
  logic [31:0]      wdata;
  logic [31:0]      rdata;

  modport ahb  (output wr, rd, addr, wdata, input rdata);
  modport core (input wr, rd, addr, wdata, output rdata);
endinterface

// [design/fpco_sync.sv]
// Module: two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module fpco_sync import fpco_pkg::*; #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fpco_sync_t;

  fpco_sync_t q;
  fpco_sync_t d;

  // ==========================================================================
  // First stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule

// [design/fpco_ahb.sv]
// Module: AHB-Lite slave front end, one wait state on reads
`timescale 1ns/100ps
module fpco_ahb import fpco_pkg::*; (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  fpco_reg_if.ahb          rb
);

  typedef struct packed {
    logic             rd_p;
    logic             wr_p;
    logic             hit;
    logic [ADDRW-1:0] addr;
    logic             rdy;
    logic [31:0]      rdata;
  } fpco_ahb_t;

  fpco_ahb_t q;
  fpco_ahb_t d;
  logic      take;

  // ==========================================================================
  // Address phase capture; read data registered so hrdata comes from a flop
  always_comb begin
    d      = q;
    d.wr_p = 1'b0;
    take   = hsel && htrans[1] && hready;
    if (q.rd_p) begin
      d.rdata = q.hit ? rb.rdata : 32'h0000_0000;
      d.rdy   = 1'b1;
      d.rd_p  = 1'b0;
    end
    if (take) begin
      // Only full words are served; other sizes read as unmapped
      d.addr = {haddr[ADDRW-1:2], 2'b00};
      d.hit  = (haddr[31:ADDRW] == 24'h00_0000) && (hsize == 3'h2);
      d.wr_p = hwrite;
      if (!hwrite) begin
        d.rd_p = 1'b1;
        d.rdy  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{rd_p: 1'b0, wr_p: 1'b0, hit: 1'b0, addr: 8'h00, rdy: 1'b1,
             rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  assign rb.wr     = q.wr_p && q.hit;
  assign rb.rd     = q.rd_p && q.hit;
  assign rb.addr   = q.addr;
  assign rb.wdata  = hwdata;
  assign hrdata    = q.rdata;
  assign hreadyout = q.rdy;
  assign hresp     = 1'b0;

endmodule

// [verif/fpco_top_sva.sv]
// Checker: port-level properties of the field pair changeover block
`timescale 1ns/100ps
module fpco_top_sva import fpco_pkg::*; (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       enable_ok,
  input wire logic [3:0] active_pair,
  input wire logic [3:0] incoming_pair,
  input wire logic       overlap_active,
  input wire logic       safety_on,
  input wire logic       cfg_fault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Bus handshake
  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wr;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd |=> s_one_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    s_wr |=> hreadyout;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write data phase stalled");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");

  // ==========================================================================
  // Outputs and pair selection
  property p_fault_off;
    // Same cycle: a commit may clear the fault and raise outputs together
    cfg_fault |-> !safety_on;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("outputs on with fault");
  // Two sync stages plus the output register fit inside five samples
  property p_enable_off;
    !enable_ok [*5] |-> !safety_on;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("outputs on without enable");
  property p_pair_range;
    active_pair < 4'ha;
  endproperty
  a_pair_range: assert property (p_pair_range) else $error("active pair out of range");
  property p_ovl_range;
    overlap_active |-> incoming_pair < 4'h5;
  endproperty
  a_ovl_range: assert property (p_ovl_range) else $error("overlap pair out of range");
  property p_ovl_end;
    $fell(overlap_active) |-> active_pair == incoming_pair;
  endproperty
  a_ovl_end: assert property (p_ovl_end) else $error("overlap ended without switch");
endmodule

bind fpco_top fpco_top_sva u_sva (
  .clk(clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .enable_ok(enable_ok),
  .active_pair(active_pair), .incoming_pair(incoming_pair),
  .overlap_active(overlap_active), .safety_on(safety_on), .cfg_fault(cfg_fault));

// [verif/fpco_sel_src.sv]
// Partner: field pair selection switches driving the select pins
`timescale 1ns/100ps
module fpco_sel_src import fpco_pkg::*; (
  input  wire logic            clk,
  input  wire logic [3:0]      pair,
  input  wire logic            vld,
  output logic      [SELW-1:0] sel
);
  // One pin per request; all low when idle, never a stale pattern
  always @(posedge clk) begin
    sel <= vld ? (SELW'(1) << pair) : '0;
  end
endmodule

// [verif/tb_top.sv]
// Testbench: directed scenarios for the field pair changeover block
`timescale 1ns/100ps
module tb_top import fpco_pkg::*; ;
  localparam logic [31:0] KEY   = 32'h0000_5afe;  // Arbitrary access key
  localparam int          LIMIT = 6000;
  logic             clk = 1'b0;
  logic             resetn, hsel, hwrite, enable_ok, unit_swap, sel_vld;
  logic [31:0]      haddr, hwdata, hrdata, rdv;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             hreadyout, hresp, overlap_active, func_b_active, safety_on, cfg_fault;
  logic [SELW-1:0]  select_inputs;
  logic [3:0]       active_pair, incoming_pair, sel_pair;
  int               miscompares, checks_done, cycles;

  always #12.5 clk = ~clk;

  fpco_top #(.ENG_KEY(KEY)) dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .select_inputs(select_inputs), .enable_ok(enable_ok), .unit_swap(unit_swap),
    .active_pair(active_pair), .incoming_pair(incoming_pair),
    .overlap_active(overlap_active), .func_b_active(func_b_active),
    .safety_on(safety_on), .cfg_fault(cfg_fault));

  fpco_sel_src u_sel (.clk(clk), .pair(sel_pair), .vld(sel_vld), .sel(select_inputs));

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single word transfer; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
    rdv = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string w);
    bus(1'b0, a, 32'h0);
    check(w, e, rdv & m);
  endtask

  task automatic wait_ovl(input logic lvl);
    int n;
    n = 0;
    while (overlap_active !== lvl && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) miscompares++;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_idle();
    rd(ADR_STATUS, 32'h3ffff, 32'h0, "status");
    rd(ADR_CTRL, 32'h7f, 32'h0, "ctrl");
    rd(8'h20, 32'hffffffff, 32'h0, "unmapped");
    check("safety", 32'h0, 32'(safety_on));
  endtask

  task automatic t_access();
    bus(1'b1, ADR_CMD, 32'h1);
    rd(ADR_STATUS, 32'h7000, 32'h1000, "refused");
    bus(1'b1, ADR_ACCESS, KEY);
    rd(ADR_ACCESS, 32'h1, 32'h1, "access");
    bus(1'b1, ADR_STATUS, 32'h1000);
  endtask

  task automatic t_defaults();
    enable_ok <= 1'b1;
    bus(1'b1, ADR_CMD, 32'h8);
    rd(ADR_CTRL, 32'h7f, 32'h0, "ctrl default");
    rd(ADR_STATUS, 32'h9000, 32'h8000, "cu ok");
    repeat (4) @(posedge clk);
    check("safety", 32'h1, 32'(safety_on));
    check("func b", 32'h0, 32'(func_b_active));
    sel_pair <= 4'h3;
    sel_vld <= 1'b1;
    repeat (10) @(posedge clk);
    check("fixed", 32'h0, 32'(active_pair));
  endtask

  task automatic t_xfer();
    sel_vld <= 1'b0;
    bus(1'b1, ADR_CMD, 32'h1);
    bus(1'b1, ADR_CTRL, 32'h35);
    bus(1'b1, ADR_TIME, 32'h3);
    bus(1'b1, ADR_SEQ, 32'h0000_0004);
    bus(1'b1, ADR_SEQ, 32'h0002_0001);
    rd(ADR_CTRL, 32'h7f, 32'h0, "ctrl staged");
    bus(1'b1, ADR_CMD, 32'h2);
    rd(ADR_CTRL, 32'h7f, 32'h35, "ctrl active");
    rd(ADR_SEQ, 32'hf03ff, 32'h20001, "seq");
    rd(ADR_STATUS, 32'h1a400, 32'h18000, "stored");
    repeat (4) @(posedge clk);
    check("safety", 32'h1, 32'(safety_on));
    check("func b", 32'h1, 32'(func_b_active));
  endtask

  task automatic t_fmom();
    sel_pair <= 4'h2;
    sel_vld <= 1'b1;
    // Late enough that a switch without the timer would already show
    repeat (6) @(posedge clk);
    check("timer", 32'h0, 32'(active_pair));
    repeat (6) @(posedge clk);
    check("pair", 32'h2, 32'(active_pair));
    sel_pair <= 4'h1;
    repeat (12) @(posedge clk);
    check("kept", 32'h2, 32'(active_pair));
    check("safety", 32'h0, 32'(safety_on));
    rd(ADR_STATUS, 32'h800, 32'h800, "viol");
    sel_pair <= 4'h0;
    repeat (12) @(posedge clk);
    check("back", 32'h0, 32'(active_pair));
    bus(1'b1, ADR_STATUS, 32'h800);
    repeat (4) @(posedge clk);
    check("safety", 32'h1, 32'(safety_on));
  endtask

  task automatic t_ovl();
    sel_vld <= 1'b0;
    bus(1'b1, ADR_CMD, 32'h1);
    bus(1'b1, ADR_CTRL, 32'h0a);
    bus(1'b1, ADR_TIME, 32'h8);
    bus(1'b1, ADR_CMD, 32'h2);
    sel_pair <= 4'h1;
    sel_vld <= 1'b1;
    repeat (12) @(posedge clk);
    check("group off", 32'h0, {27'h0, overlap_active, active_pair});
    sel_pair <= 4'h8;
    wait_ovl(1'b1);
    check("incoming", 32'h3, 32'(incoming_pair));
    check("outgoing", 32'h0, 32'(active_pair));
    repeat (4) @(posedge clk);
    check("overlap", 32'h1, 32'(overlap_active));
    wait_ovl(1'b0);
    check("switched", 32'h3, 32'(active_pair));
  endtask

  task automatic t_swap();
    unit_swap <= 1'b1;
    repeat (4) @(posedge clk);
    check("swap pair", 32'h0, 32'(active_pair));
    unit_swap <= 1'b0;
    rd(ADR_CTRL, 32'h7f, 32'h0a, "copied");
    rd(ADR_STATUS, 32'h18000, 32'h18000, "units ok");
  endtask

  task automatic t_fault();
    bus(1'b1, ADR_CMD, 32'h1);
    bus(1'b1, ADR_CTRL, 32'h3);
    bus(1'b1, ADR_CMD, 32'h2);
    repeat (3) @(posedge clk);
    check("fault", 32'h1, 32'(cfg_fault));
    check("safety", 32'h0, 32'(safety_on));
    rd(ADR_CTRL, 32'h7f, 32'h0a, "ctrl kept");
    bus(1'b1, ADR_CMD, 32'h8);
    bus(1'b1, ADR_CMD, 32'h1);
    bus(1'b1, ADR_CMD, 32'h4);
    rd(ADR_STATUS, 32'h2400, 32'h400, "aborted");
  endtask

  // ==========================================================================
  // Timeout and main sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    {resetn, hsel, hwrite, enable_ok, unit_swap, sel_vld} = '0;
    {haddr, hwdata, htrans, hsize, sel_pair} = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_idle();
    t_access();
    t_defaults();
    t_xfer();
    t_fmom();
    t_ovl();
    t_swap();
    t_fault();
    complete_run();
  end
endmodule
